// ==== common/gate_ctrl_pkg.sv ====
// constants, register map and enumerations of the half-bridge gate control block
// assumes a 50 MHz system clock and a 32-bit classic Wishbone register port
package gate_ctrl_pkg;
  localparam int NUM_BRIDGES = 3;
  localparam int CUR_W = 6;
  // register byte offsets
  localparam logic [7:0] OFS_GEN = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_ICHG = 8'h08;
  localparam logic [7:0] OFS_INIT = 8'h14;
  localparam logic [7:0] OFS_TPRE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_ADAPT = 8'h30;
  // general_gate_setting fields
  localparam int GEN_NB_BIT = 0;
  localparam int GEN_DETECT_BIT = 1;
  localparam int GEN_SCHEME_LSB = 2;
  localparam int GEN_SPLIT_BIT = 4;
  localparam int GEN_HOLD_LSB = 8;
  // mode word: one nibble per bridge
  localparam int MODE_W = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_EN_BIT = 2;
  localparam int MODE_AFW_BIT = 3;
  // bridge_current_setting fields
  localparam int ICHG_CHG_LSB = 0;
  localparam int ICHG_DCHG_LSB = 8;
  localparam int ICHG_FW_LSB = 16;
  localparam int ICHG_LIM_LSB = 24;
  // prephase_initial_setting and prephase_duration_setting fields
  localparam int INIT_PCHG_LSB = 0;
  localparam int INIT_PDCHG_LSB = 8;
  localparam int TPRE_PCHG_LSB = 0;
  localparam int TPRE_PDCHG_LSB = 8;
  // reset values
  localparam logic [31:0] RST_GEN = 32'h0000_0400;
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_ICHG = 32'h3f10_1010;
  localparam logic [31:0] RST_INIT = 32'h0000_0808;
  localparam logic [31:0] RST_TPRE = 32'h0000_2020;
  // current codes: minimum prephase step and hard-off sink (discharge code 63)
  localparam logic [CUR_W-1:0] MIN_PREPHASE_CODE = 6'h01;
  localparam logic [CUR_W-1:0] HARD_OFF_CODE = 6'h3f;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int SWITCH_TIME_NS = 2000;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    MODE_PASSIVE_OFF = 2'b00,
    MODE_LOW_PWM = 2'b01,
    MODE_HIGH_PWM = 2'b10,
    MODE_ACTIVE_OFF = 2'b11
  } bridge_mode_e;
  typedef enum logic [1:0] {
    PH_HOLD = 2'b00,
    PH_PRE_A = 2'b01,
    PH_PRE_B = 2'b10,
    PH_MAIN = 2'b11
  } phase_e;
endpackage

// ==== src/pin_sync3.sv ====
// three-stage synchroniser for asynchronous pin inputs
// assumes one clock; output follows once the second and third stage agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_out;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pin_sync3 needs WIDTH of at least 1");
    end
  endgenerate

  // accept a level only where stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_out[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
    end
  end

  // shift chain, first stage read only by the second
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_out;
    end
  end
endmodule
`default_nettype wire

// ==== src/half_bridge_gate_ctrl.sv ====
// gate control sequencer for three half-bridges driven by three pwm inputs
// assumes a Wishbone master for configuration and external gate drivers
`timescale 1ns/1ps
`default_nettype none
module half_bridge_gate_ctrl (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output var logic [31:0] WB_DAT_O,
  output var logic WB_ACK_O,
  input wire logic PWM_INPUT_ONE,
  input wire logic PWM_INPUT_THREE,
  input wire logic PWM_INPUT_FIVE,
  input wire logic [2:0] DELAY_LONG,
  output var logic [2:0] HIGH_SIDE_ON,
  output var logic [2:0] LOW_SIDE_ON,
  output var logic [17:0] HIGH_SIDE_CURRENT,
  output var logic [17:0] LOW_SIDE_CURRENT,
  output var logic [2:0] HIGH_SIDE_SINK,
  output var logic [2:0] LOW_SIDE_SINK,
  output var logic [2:0] PASSIVE_DISCHARGE
);
  localparam int NB = gate_ctrl_pkg::NUM_BRIDGES;
  localparam int CW = gate_ctrl_pkg::CUR_W;
  localparam logic [7:0] SW_LOAD = 8'(gate_ctrl_pkg::SWITCH_CYCLES - 1);
  localparam logic [CW-1:0] CMIN = gate_ctrl_pkg::MIN_PREPHASE_CODE;

  generate
    if (gate_ctrl_pkg::SWITCH_CYCLES > 256 || gate_ctrl_pkg::SWITCH_CYCLES < 1) begin : g_bad
      $error("switching phase does not fit the 8-bit phase counter");
    end
  endgenerate

  logic [31:0] gen, next_gen, mode_reg, next_mode;
  logic [31:0] ichg [NB];
  logic [31:0] next_ichg [NB];
  logic [31:0] init [NB];
  logic [31:0] next_init [NB];
  logic [31:0] tpre [NB];
  logic [31:0] next_tpre [NB];
  logic [31:0] rdata, next_dat;
  logic req, next_ack;
  logic [2:0] pwm_sync, slow;
  logic [5:0] sync_q;

  gate_ctrl_pkg::phase_e phase [NB];
  gate_ctrl_pkg::phase_e next_phase [NB];
  logic [7:0] cnt [NB];
  logic [7:0] next_cnt [NB];
  logic [CW-1:0] pre_chg [NB];
  logic [CW-1:0] next_pchg [NB];
  logic [CW-1:0] pre_dchg [NB];
  logic [CW-1:0] next_pdchg [NB];
  logic [NB-1:0] dir, next_dir, last_tgt, next_last;
  logic [NB-1:0] pwm_sel, afw_on, tgt, leave, adapt_chg, adapt_dchg;
  logic [7:0] len_new [NB];
  logic [7:0] len_cur [NB];
  logic [7:0] half_new [NB];
  logic [7:0] half_cur [NB];
  logic [CW-1:0] lim [NB];
  logic [2:0] next_hs_on, next_ls_on, next_hs_sink, next_ls_sink, next_passive;
  logic [17:0] next_hs_cur, next_ls_cur;
  logic [CW-1:0] pwm_cur, oth_cur, pre_now, hold_cur;
  logic pwm_sink, oth_sink, oth_on;
  gate_ctrl_pkg::bridge_mode_e msel;
  gate_ctrl_pkg::bridge_mode_e seq_mode;
  logic [1:0] scheme;

  // one step of the adaptive current, clamped to minimum and limit
  function automatic logic [CW-1:0] step_cur(input logic [CW-1:0] v, input logic up,
                                             input logic [CW-1:0] lmt);
    logic [CW:0] t;
    t = {1'b0, v};
    if (up) begin
      t = t + 7'h01;
    end else if (v != '0) begin
      t = t - 7'h01;
    end
    if (t > {1'b0, lmt}) begin
      t = {1'b0, lmt};
    end
    if (t < {1'b0, CMIN}) begin
      t = {1'b0, CMIN};
    end
    return t[CW-1:0];
  endfunction

  // byte-lane merge of a Wishbone write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (val & m);
  endfunction

  // pwm pins and delay comparators cross into the clock domain
  pin_sync3 #(.WIDTH(6)) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .async_in({DELAY_LONG, PWM_INPUT_FIVE, PWM_INPUT_THREE, PWM_INPUT_ONE}),
    .sync_out(sync_q)
  );
  assign pwm_sync = sync_q[2:0];
  assign slow = sync_q[5:3];
  assign scheme = gen[gate_ctrl_pkg::GEN_SCHEME_LSB +: 2];
  assign hold_cur = gen[gate_ctrl_pkg::GEN_HOLD_LSB +: CW];

  // register read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0;
    if (WB_ADR_I == gate_ctrl_pkg::OFS_GEN) rdata = gen;
    if (WB_ADR_I == gate_ctrl_pkg::OFS_MODE) rdata = mode_reg;
    for (int b = 0; b < NB; b++) begin
      if (WB_ADR_I == gate_ctrl_pkg::OFS_ICHG + 8'(4 * b)) rdata = ichg[b];
      if (WB_ADR_I == gate_ctrl_pkg::OFS_INIT + 8'(4 * b)) rdata = init[b];
      if (WB_ADR_I == gate_ctrl_pkg::OFS_TPRE + 8'(4 * b)) rdata = tpre[b];
      if (WB_ADR_I == gate_ctrl_pkg::OFS_ADAPT + 8'(4 * b)) begin
        rdata = {18'h0, pre_dchg[b], 2'b00, pre_chg[b]};
      end
      if (WB_ADR_I == gate_ctrl_pkg::OFS_STATUS) begin
        rdata[b] = pwm_sync[b];
        rdata[3 + b] = HIGH_SIDE_ON[b];
        rdata[6 + b] = LOW_SIDE_ON[b];
        rdata[9 + b] = (phase[b] != gate_ctrl_pkg::PH_HOLD);
      end
    end
  end

  // bus slave: ack one cycle after the request, writes take effect with it
  always_comb begin
    req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    next_ack = req;
    next_dat = req ? rdata : 32'h0;
    next_gen = gen;
    next_mode = mode_reg;
    next_ichg = ichg;
    next_init = init;
    next_tpre = tpre;
    if (req && WB_WE_I) begin
      if (WB_ADR_I == gate_ctrl_pkg::OFS_GEN) next_gen = merge(gen, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == gate_ctrl_pkg::OFS_MODE) next_mode = merge(mode_reg, WB_DAT_I, WB_SEL_I);
      for (int b = 0; b < NB; b++) begin
        if (WB_ADR_I == gate_ctrl_pkg::OFS_ICHG + 8'(4 * b)) begin
          next_ichg[b] = merge(ichg[b], WB_DAT_I, WB_SEL_I);
        end
        if (WB_ADR_I == gate_ctrl_pkg::OFS_INIT + 8'(4 * b)) begin
          next_init[b] = merge(init[b], WB_DAT_I, WB_SEL_I);
        end
        if (WB_ADR_I == gate_ctrl_pkg::OFS_TPRE + 8'(4 * b)) begin
          next_tpre[b] = merge(tpre[b], WB_DAT_I, WB_SEL_I);
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      gen <= gate_ctrl_pkg::RST_GEN;
      mode_reg <= gate_ctrl_pkg::RST_MODE;
      for (int b = 0; b < NB; b++) begin
        ichg[b] <= gate_ctrl_pkg::RST_ICHG;
        init[b] <= gate_ctrl_pkg::RST_INIT;
        tpre[b] <= gate_ctrl_pkg::RST_TPRE;
      end
    end else begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_dat;
      gen <= next_gen;
      mode_reg <= next_mode;
      ichg <= next_ichg;
      init <= next_init;
      tpre <= next_tpre;
    end
  end

  // per-bridge phase sequencer and current adaptation
  always_comb begin
    seq_mode = gate_ctrl_pkg::MODE_PASSIVE_OFF;
    for (int b = 0; b < NB; b++) begin
      seq_mode = gate_ctrl_pkg::bridge_mode_e'(mode_reg[b * 4 +: 2]);
      pwm_sel[b] = mode_reg[b * 4 + gate_ctrl_pkg::MODE_EN_BIT] && !gen[gate_ctrl_pkg::GEN_NB_BIT]
                   && (seq_mode == gate_ctrl_pkg::MODE_LOW_PWM
                       || seq_mode == gate_ctrl_pkg::MODE_HIGH_PWM);
      afw_on[b] = pwm_sel[b] && mode_reg[b * 4 + gate_ctrl_pkg::MODE_AFW_BIT];
      tgt[b] = pwm_sync[b];
      lim[b] = ichg[b][gate_ctrl_pkg::ICHG_LIM_LSB +: CW];
      len_new[b] = tgt[b] ? tpre[b][gate_ctrl_pkg::TPRE_PCHG_LSB +: 8]
                          : tpre[b][gate_ctrl_pkg::TPRE_PDCHG_LSB +: 8];
      len_cur[b] = dir[b] ? tpre[b][gate_ctrl_pkg::TPRE_PCHG_LSB +: 8]
                          : tpre[b][gate_ctrl_pkg::TPRE_PDCHG_LSB +: 8];
      half_new[b] = gen[gate_ctrl_pkg::GEN_SPLIT_BIT] ? (len_new[b] >> 1) : 8'h00;
      half_cur[b] = gen[gate_ctrl_pkg::GEN_SPLIT_BIT] ? (len_cur[b] >> 1) : 8'h00;
      next_phase[b] = phase[b];
      next_cnt[b] = cnt[b];
      next_dir[b] = dir[b];
      next_last[b] = last_tgt[b];
      next_pchg[b] = pre_chg[b];
      next_pdchg[b] = pre_dchg[b];
      leave[b] = 1'b0;
      if (!pwm_sel[b] || !scheme[1]) begin
        next_pchg[b] = init[b][gate_ctrl_pkg::INIT_PCHG_LSB +: CW];
        next_pdchg[b] = init[b][gate_ctrl_pkg::INIT_PDCHG_LSB +: CW];
      end
      if (!pwm_sel[b]) begin
        next_phase[b] = gate_ctrl_pkg::PH_HOLD;
        next_cnt[b] = 8'h00;
        next_dir[b] = 1'b0;
        next_last[b] = 1'b0;
      end else if (tgt[b] != last_tgt[b]) begin
        next_last[b] = tgt[b];
        next_dir[b] = tgt[b];
        if (scheme == 2'b00 || len_new[b] == half_new[b]) begin
          next_phase[b] = gate_ctrl_pkg::PH_MAIN;
          next_cnt[b] = SW_LOAD;
        end else begin
          next_phase[b] = gate_ctrl_pkg::PH_PRE_A;
          next_cnt[b] = len_new[b] - half_new[b] - 8'h01;
        end
      end else begin
        case (phase[b])
          gate_ctrl_pkg::PH_PRE_A: begin
            if (cnt[b] != 8'h00) begin
              next_cnt[b] = cnt[b] - 8'h01;
            end else if (half_cur[b] != 8'h00) begin
              next_phase[b] = gate_ctrl_pkg::PH_PRE_B;
              next_cnt[b] = half_cur[b] - 8'h01;
            end else begin
              leave[b] = 1'b1;
            end
          end
          gate_ctrl_pkg::PH_PRE_B: begin
            if (cnt[b] != 8'h00) next_cnt[b] = cnt[b] - 8'h01;
            else leave[b] = 1'b1;
          end
          gate_ctrl_pkg::PH_MAIN: begin
            if (cnt[b] != 8'h00) next_cnt[b] = cnt[b] - 8'h01;
            else next_phase[b] = gate_ctrl_pkg::PH_HOLD;
          end
          default: next_phase[b] = gate_ctrl_pkg::PH_HOLD;
        endcase
      end
      adapt_chg[b] = leave[b] && scheme[1] && dir[b];
      adapt_dchg[b] = leave[b] && scheme[1] && !dir[b];
      if (leave[b]) begin
        next_phase[b] = gate_ctrl_pkg::PH_MAIN;
        next_cnt[b] = SW_LOAD;
      end
      if (adapt_chg[b]) next_pchg[b] = step_cur(pre_chg[b], slow[b], lim[b]);
      if (adapt_dchg[b]) next_pdchg[b] = step_cur(pre_dchg[b], slow[b], lim[b]);
    end
  end

  // gate commands and drive currents for both switches of every bridge
  always_comb begin
    next_hs_on = '0;
    next_ls_on = '0;
    next_hs_sink = '0;
    next_ls_sink = '0;
    next_passive = '0;
    next_hs_cur = '0;
    next_ls_cur = '0;
    msel = gate_ctrl_pkg::MODE_PASSIVE_OFF;
    pwm_cur = '0;
    oth_cur = '0;
    pre_now = '0;
    pwm_sink = 1'b0;
    oth_sink = 1'b0;
    oth_on = 1'b0;
    for (int b = 0; b < NB; b++) begin
      msel = gate_ctrl_pkg::bridge_mode_e'(mode_reg[b * 4 +: 2]);
      pre_now = dir[b] ? pre_chg[b] : pre_dchg[b];
      case (phase[b])
        gate_ctrl_pkg::PH_PRE_A: pwm_cur = pre_now;
        gate_ctrl_pkg::PH_PRE_B: pwm_cur = ((pre_now >> 1) < CMIN) ? CMIN : (pre_now >> 1);
        gate_ctrl_pkg::PH_MAIN: begin
          pwm_cur = dir[b] ? ichg[b][gate_ctrl_pkg::ICHG_CHG_LSB +: CW]
                           : ichg[b][gate_ctrl_pkg::ICHG_DCHG_LSB +: CW];
        end
        default: pwm_cur = hold_cur;
      endcase
      pwm_sink = (phase[b] == gate_ctrl_pkg::PH_HOLD) ? !last_tgt[b] : !dir[b];
      oth_on = afw_on[b] && !last_tgt[b];
      oth_sink = !oth_on;
      if (phase[b] == gate_ctrl_pkg::PH_HOLD) oth_cur = hold_cur;
      else if (afw_on[b]) oth_cur = ichg[b][gate_ctrl_pkg::ICHG_FW_LSB +: CW];
      else if (dir[b]) oth_cur = gate_ctrl_pkg::HARD_OFF_CODE;
      else oth_cur = hold_cur;
      if (msel == gate_ctrl_pkg::MODE_PASSIVE_OFF) begin
        next_passive[b] = 1'b1;
      end else if (!pwm_sel[b]) begin
        next_hs_sink[b] = 1'b1;
        next_ls_sink[b] = 1'b1;
        next_hs_cur[b * CW +: CW] = hold_cur;
        next_ls_cur[b * CW +: CW] = hold_cur;
      end else if (msel == gate_ctrl_pkg::MODE_HIGH_PWM) begin
        next_hs_on[b] = last_tgt[b];
        next_hs_sink[b] = pwm_sink;
        next_hs_cur[b * CW +: CW] = pwm_cur;
        next_ls_on[b] = oth_on;
        next_ls_sink[b] = oth_sink;
        next_ls_cur[b * CW +: CW] = oth_cur;
      end else begin
        next_ls_on[b] = last_tgt[b];
        next_ls_sink[b] = pwm_sink;
        next_ls_cur[b * CW +: CW] = pwm_cur;
        next_hs_on[b] = oth_on;
        next_hs_sink[b] = oth_sink;
        next_hs_cur[b * CW +: CW] = oth_cur;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int b = 0; b < NB; b++) begin
        phase[b] <= gate_ctrl_pkg::PH_HOLD;
        cnt[b] <= 8'h00;
        pre_chg[b] <= gate_ctrl_pkg::RST_INIT[gate_ctrl_pkg::INIT_PCHG_LSB +: CW];
        pre_dchg[b] <= gate_ctrl_pkg::RST_INIT[gate_ctrl_pkg::INIT_PDCHG_LSB +: CW];
      end
      dir <= '0;
      last_tgt <= '0;
      HIGH_SIDE_ON <= '0;
      LOW_SIDE_ON <= '0;
      HIGH_SIDE_SINK <= '0;
      LOW_SIDE_SINK <= '0;
      HIGH_SIDE_CURRENT <= '0;
      LOW_SIDE_CURRENT <= '0;
      PASSIVE_DISCHARGE <= 3'h7;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      pre_chg <= next_pchg;
      pre_dchg <= next_pdchg;
      dir <= next_dir;
      last_tgt <= next_last;
      HIGH_SIDE_ON <= next_hs_on;
      LOW_SIDE_ON <= next_ls_on;
      HIGH_SIDE_SINK <= next_hs_sink;
      LOW_SIDE_SINK <= next_ls_sink;
      HIGH_SIDE_CURRENT <= next_hs_cur;
      LOW_SIDE_CURRENT <= next_ls_cur;
      PASSIVE_DISCHARGE <= next_passive;
    end
  end

  // checks on bridge one
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire cfg_low0 = mode_reg[3:0] == 4'b0101 && !gen[0];
  wire cfg_high0 = mode_reg[3:0] == 4'b1110 && !gen[0];
  wire cfg_pasv0 = mode_reg[3:0] == 4'b0110 && !gen[0];
  sequence s_pre_end0;
    phase[0] == gate_ctrl_pkg::PH_PRE_A && cnt[0] == 8'h00;
  endsequence
  sequence s_split_pending0;
    half_cur[0] != 8'h00 && tgt[0] == last_tgt[0];
  endsequence

  AST_PASSIVE_OFF: assert property (mode_reg[1:0] == 2'b00 |=>
    PASSIVE_DISCHARGE[0] && !HIGH_SIDE_ON[0] && !LOW_SIDE_ON[0]) else $error("passive off lost");
  AST_ACTIVE_OFF: assert property (mode_reg[1:0] == 2'b11 |=>
    !PASSIVE_DISCHARGE[0] && !HIGH_SIDE_ON[0] && !LOW_SIDE_ON[0] && HIGH_SIDE_SINK[0]
    && LOW_SIDE_SINK[0]) else $error("active off lost");
  AST_LOW_PWM: assert property ((cfg_low0 && pwm_sync[0]) [*2] |=>
    LOW_SIDE_ON[0] && !HIGH_SIDE_ON[0]) else $error("low side pwm wrong");
  AST_LOW_PWM_OFF: assert property ((cfg_low0 && !pwm_sync[0]) [*2] |=>
    !LOW_SIDE_ON[0] && !HIGH_SIDE_ON[0]) else $error("low side pwm off wrong");
  AST_HIGH_PWM: assert property ((cfg_high0 && !pwm_sync[0]) [*2] |=>
    LOW_SIDE_ON[0] && !HIGH_SIDE_ON[0]) else $error("freewheel low side missing");
  AST_HIGH_HARD_OFF: assert property (cfg_pasv0 && phase[0] != gate_ctrl_pkg::PH_HOLD && dir[0]
    |=> LOW_SIDE_CURRENT[5:0] == gate_ctrl_pkg::HARD_OFF_CODE && LOW_SIDE_SINK[0])
    else $error("hard off current missing");
  AST_SKIP_PRE: assert property (phase[0] != gate_ctrl_pkg::PH_PRE_A && scheme == 2'b00
    |=> phase[0] != gate_ctrl_pkg::PH_PRE_A) else $error("prephase entered with scheme 00");
  AST_CLAMP_CHG: assert property (adapt_chg[0] && lim[0] >= CMIN |=>
    pre_chg[0] >= CMIN && pre_chg[0] <= $past(lim[0])) else $error("precharge not clamped");
  AST_CLAMP_DCHG: assert property (adapt_dchg[0] && lim[0] >= CMIN |=>
    pre_dchg[0] >= CMIN && pre_dchg[0] <= $past(lim[0])) else $error("predischarge not clamped");
  AST_INIT_LOAD: assert property (!pwm_sel[0] |=>
    pre_chg[0] == $past(init[0][5:0]) && pre_dchg[0] == $past(init[0][13:8]))
    else $error("initial prephase value not loaded");
  AST_SPLIT: assert property (s_pre_end0 ##0 s_split_pending0 ##0 pwm_sel[0] |=>
    phase[0] == gate_ctrl_pkg::PH_PRE_B) else $error("second prephase part missing");
endmodule
`default_nettype wire

// ==== verification/gate_drv_model.sv ====
// far side model: host pwm pins and the external gate drivers
// assumes the bench picks pwm levels and how slowly the drivers switch
`timescale 1ns/1ps
`default_nettype none
module gate_drv_model (
  input wire logic clk,
  input wire logic [2:0] pwm_level,
  input wire logic [2:0] slow,
  output var logic [2:0] pwm_pin = 3'h0,
  output var logic [2:0] delay_long = 3'h0
);
  // pins follow the bench's levels one rising edge later
  always @(posedge clk) begin
    pwm_pin <= pwm_level;
    delay_long <= slow;
  end
endmodule
`default_nettype wire

// ==== verification/half_bridge_pwm_gate_control_tb.sv ====
// self-checking bench for the three-bridge gate control block
// assumes the gate driver model is compiled before this file
`timescale 1ns/1ps
`default_nettype none
module half_bridge_pwm_gate_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] pwm_level = 3'h0;
  logic [2:0] slow = 3'h0;
  logic [2:0] pin, dl, hs_on, ls_on, hs_sink, ls_sink, passive;
  logic [17:0] hs_cur, ls_cur;
  logic [31:0] dur [3];
  logic [63:0] note;
  logic [63:0] expq [$];
  int num_errors = 0;
  int n_checks = 0;
  int seed = 5667;
  // 50 MHz clock
  always #10 clk = ~clk;
  half_bridge_gate_ctrl DUT (.CLOCK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PWM_INPUT_ONE(pin[0]), .PWM_INPUT_THREE(pin[1]),
    .PWM_INPUT_FIVE(pin[2]), .DELAY_LONG(dl), .HIGH_SIDE_ON(hs_on), .LOW_SIDE_ON(ls_on),
    .HIGH_SIDE_CURRENT(hs_cur), .LOW_SIDE_CURRENT(ls_cur), .HIGH_SIDE_SINK(hs_sink),
    .LOW_SIDE_SINK(ls_sink), .PASSIVE_DISCHARGE(passive));
  gate_drv_model PEER (.clk(clk), .pwm_level(pwm_level), .slow(slow), .pwm_pin(pin),
    .delay_long(dl));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  // note the masked expectation, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    expq.push_back({m, v});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input int n);
    pwm_level <= 3'b111;
    repeat (n) @(posedge clk);
    pwm_level <= 3'b000;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_hs();
    int n;
    n = 0;
    while (hs_on[0] !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) num_errors++;
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = expq.pop_front();
      check(rdat & note[63:32], note[31:0]);
    end
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(passive, 32'h7);
    rd(gate_ctrl_pkg::OFS_GEN, 32'h3f1f, gate_ctrl_pkg::RST_GEN);
    rd(gate_ctrl_pkg::OFS_MODE, 32'hfff, 32'h0);
    for (int b = 0; b < 3; b++) begin
      rd(gate_ctrl_pkg::OFS_ICHG + 8'(4 * b), 32'h3f3f3f3f, gate_ctrl_pkg::RST_ICHG);
      rd(gate_ctrl_pkg::OFS_INIT + 8'(4 * b), 32'h3f3f, gate_ctrl_pkg::RST_INIT);
      rd(gate_ctrl_pkg::OFS_TPRE + 8'(4 * b), 32'hffff, gate_ctrl_pkg::RST_TPRE);
      dur[b] = $random(seed);
      wr(gate_ctrl_pkg::OFS_TPRE + 8'(4 * b), dur[b]);
    end
    for (int b = 0; b < 3; b++) begin
      rd(gate_ctrl_pkg::OFS_TPRE + 8'(4 * b), 32'hffff, dur[b] & 32'hffff);
    end
    wr(gate_ctrl_pkg::OFS_TPRE, 32'h2020);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'hffffffff, 32'h0);
    wr(gate_ctrl_pkg::OFS_STATUS, 32'h1ff);
    rd(gate_ctrl_pkg::OFS_STATUS, 32'hfff, 32'h0);
    // every bridge mode, pwm high then low
    for (int m = 0; m < 4; m++) begin
      for (int p = 1; p >= 0; p--) begin
        wr(gate_ctrl_pkg::OFS_MODE, 32'({3{m == 2, 1'b1, 2'(m)}}));
        pwm_level <= {3{p[0]}};
        repeat (12) @(posedge clk);
        rd(gate_ctrl_pkg::OFS_STATUS, 32'h1ff, {23'h0, {3{m == 1 ? p[0] : m == 2 && !p[0]}},
          {3{m == 2 && p[0]}}, {3{p[0]}}});
        check(passive, 32'({3{m == 0}}));
      end
    end
    // six-input select, then enable off: pwm must be ignored
    for (int k = 0; k < 2; k++) begin
      wr(gate_ctrl_pkg::OFS_GEN, 32'h400 | 32'(1 - k));
      wr(gate_ctrl_pkg::OFS_MODE, k ? 32'haaa : 32'heee);
      pwm_level <= 3'b111;
      repeat (12) @(posedge clk);
      rd(gate_ctrl_pkg::OFS_STATUS, 32'h1ff, 32'h7);
      pwm_level <= 3'b000;
      repeat (12) @(posedge clk);
    end
    // adaptive scheme, limit 9, slow then fast driver
    wr(gate_ctrl_pkg::OFS_GEN, 32'h408);
    wr(gate_ctrl_pkg::OFS_MODE, 32'heee);
    wr(gate_ctrl_pkg::OFS_ICHG, 32'h09101010);
    rd(gate_ctrl_pkg::OFS_ADAPT, 32'h3f3f, 32'h0808);
    slow <= 3'b111;
    repeat (3) pulse(150);
    rd(gate_ctrl_pkg::OFS_ADAPT, 32'h3f3f, 32'h0909);
    slow <= 3'b000;
    repeat (10) pulse(150);
    rd(gate_ctrl_pkg::OFS_ADAPT, 32'h3f3f, 32'h0101);
    pwm_level <= 3'b111;
    wait_hs();
    repeat (2) @(negedge clk);
    check(hs_cur[5:0], 32'h1);
    check(ls_cur[5:0], 32'h10);
    repeat (200) @(negedge clk);
    check({hs_sink[0], hs_cur[5:0]}, 32'h4);
    pwm_level <= 3'b000;
    repeat (200) @(posedge clk);
    // split on, split off, scheme 00; no active freewheel
    wr(gate_ctrl_pkg::OFS_MODE, 32'h666);
    for (int k = 0; k < 3; k++) begin
      wr(gate_ctrl_pkg::OFS_GEN, k == 0 ? 32'h414 : k == 1 ? 32'h404 : 32'h400);
      pwm_level <= 3'b111;
      wait_hs();
      repeat (2) @(negedge clk);
      check(hs_cur[5:0], k == 2 ? 32'h10 : 32'h8);
      check({ls_sink[0], ls_cur[5:0]}, 32'h7f);
      repeat (22) @(negedge clk);
      check(hs_cur[5:0], k == 0 ? 32'h4 : k == 1 ? 32'h8 : 32'h10);
      pwm_level <= 3'b000;
      repeat (200) @(posedge clk);
    end
    rd(gate_ctrl_pkg::OFS_ADAPT, 32'h3f3f, 32'h0808);
    give_verdict();
  end
endmodule
`default_nettype wire
